// file: core/srl_latch_unit.v
// set/reset latch unit with selectable sources, pulse clock divider and apb registers
// Overview of operation
// - latch runs only while enable bit is one
// - divider code picks pulse period four to 512
// - true output driven to pin when enabled
// - inverted output driven to pin when enabled
// - soft set bit pulses set, reads zero
// - soft reset bit pulses reset, reads zero
// - external pin level sets latch when enabled
// - divided clock pulses set input when enabled
// - comparator two sets latch when enabled
// - comparator one sets latch when enabled
// - external pin resets latch when enabled
// - divided clock pulses reset input when enabled
// - comparator two resets latch when enabled
// - comparator one resets latch when enabled
// - reset wins when set and reset both high
// - all set and reset inputs active high
// - soft pulse bits clear themselves after one write
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ns
`include "srl_map.vh"

module srl_latch_unit #(
    parameter CLK_HZ = 25000000
) (
    // clock, reset, clock enable
    input wire mclk_i,
    input wire rst_i,
    input wire ce_i,
    // apb slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [3:0] pstrb_i,
    output wire pready_o,
    output reg [31:0] prdata_o,
    output wire pslverr_o,
    // set/reset sources
    input wire external_interrupt_pin_i,
    input wire comparator_one_i,
    input wire comparator_two_i,
    // latch outputs
    output wire latch_q_o,
    output wire latch_qn_o,
    output wire true_output_pin_o,
    output wire true_output_pin_oe_o,
    output wire inverted_output_pin_o,
    output wire inverted_output_pin_oe_o
);

    // =====================================================================
    // functions

    // one-hot of the selected divider period minus one, used as a count limit
    function [`SRL_DIV_CNT_W-1:0] srl_div_last;
        input [2:0] code;
        reg [`SRL_DIV_CNT_W-1:0] one;
        begin
            one = {{(`SRL_DIV_CNT_W-1){1'b0}}, 1'b1};
            srl_div_last = (one << (code + `SRL_DIV_BASE_LOG2)) - one;
        end
    endfunction

    function srl_hit;
        input [11:0] addr;
        input [11:0] ofs;
        begin
            srl_hit = (addr[11:2] == ofs[11:2]);
        end
    endfunction

    // =====================================================================
    // pin synchronisers

    reg [2:0] sync1_q;
    reg [2:0] sync2_q;
    wire pin_s;
    wire cmp1_s;
    wire cmp2_s;

    always @(posedge mclk_i) begin
        if (rst_i) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end else if (ce_i) begin
            sync1_q <= {comparator_two_i, comparator_one_i, external_interrupt_pin_i};
            sync2_q <= sync1_q;
        end
    end

    assign pin_s = sync2_q[0];
    assign cmp1_s = sync2_q[1];
    assign cmp2_s = sync2_q[2];

    // =====================================================================
    // registers

    reg [7:0] ctrl_q;
    reg [7:0] src_q;
    reg soft_set_q;
    reg soft_rst_q;
    wire wr_en;
    wire rd_en;
    wire addr_ok;

    wire latch_unit_enable = ctrl_q[`SRL_EN_BIT];
    wire [2:0] pulse_clock_divider = ctrl_q[`SRL_DIV_HI:`SRL_DIV_LO];
    wire true_output_pin_enable = ctrl_q[`SRL_QEN_BIT];
    wire inverted_output_pin_enable = ctrl_q[`SRL_NQEN_BIT];

    assign addr_ok = srl_hit(paddr_i, `SRL_CTRL_OFS) || srl_hit(paddr_i, `SRL_SRC_OFS)
        || srl_hit(paddr_i, `SRL_STAT_OFS);
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !addr_ok;
    assign wr_en = psel_i && penable_i && pwrite_i && ce_i && pstrb_i[0];
    assign rd_en = psel_i && !penable_i && !pwrite_i && ce_i;

    always @(posedge mclk_i) begin
        if (rst_i) begin
            ctrl_q <= `SRL_CTRL_RST;
            src_q <= `SRL_SRC_RST;
            soft_set_q <= 1'b0;
            soft_rst_q <= 1'b0;
        end else if (ce_i) begin
            // pulse bits are never stored: one cycle, then gone
            soft_set_q <= 1'b0;
            soft_rst_q <= 1'b0;
            if (wr_en && srl_hit(paddr_i, `SRL_CTRL_OFS)) begin
                ctrl_q <= {pwdata_i[7:2], 2'b00};
                soft_set_q <= pwdata_i[`SRL_PS_BIT];
                soft_rst_q <= pwdata_i[`SRL_PR_BIT];
            end else if (wr_en && srl_hit(paddr_i, `SRL_SRC_OFS)) begin
                src_q <= pwdata_i[7:0];
            end
        end
    end

    // =====================================================================
    // pulse clock divider

    reg [`SRL_DIV_CNT_W-1:0] div_cnt_q;
    reg div_pulse_q;

    // divider free-runs only while enabled; a code change mid-period may give
    // one short period, which software is expected to avoid
    always @(posedge mclk_i) begin
        if (rst_i) begin
            div_cnt_q <= {`SRL_DIV_CNT_W{1'b0}};
            div_pulse_q <= 1'b0;
        end else if (ce_i) begin
            if (!latch_unit_enable) begin
                div_cnt_q <= {`SRL_DIV_CNT_W{1'b0}};
                div_pulse_q <= 1'b0;
            end else if (div_cnt_q >= srl_div_last(pulse_clock_divider)) begin
                div_cnt_q <= {`SRL_DIV_CNT_W{1'b0}};
                div_pulse_q <= 1'b1;
            end else begin
                div_cnt_q <= div_cnt_q + {{(`SRL_DIV_CNT_W-1){1'b0}}, 1'b1};
                div_pulse_q <= 1'b0;
            end
        end
    end

    // =====================================================================
    // set/reset gathering and the latch

    wire set_in;
    wire rst_in;
    reg latch_q;

    // all sources active high; pin, clock and comparators gated by src_q, soft pulses ungated, all ored
    assign set_in = (src_q[`SRL_S_PIN_BIT] & pin_s)
        | (src_q[`SRL_S_CLK_BIT] & div_pulse_q)
        | (src_q[`SRL_S_C2_BIT] & cmp2_s)
        | (src_q[`SRL_S_C1_BIT] & cmp1_s)
        | soft_set_q;
    assign rst_in = (src_q[`SRL_R_PIN_BIT] & pin_s)
        | (src_q[`SRL_R_CLK_BIT] & div_pulse_q)
        | (src_q[`SRL_R_C2_BIT] & cmp2_s)
        | (src_q[`SRL_R_C1_BIT] & cmp1_s)
        | soft_rst_q;

    // the latch keeps its state through rst_i on purpose: device reset does not
    // initialise it; it starts at zero only so simulation has a known value
    initial latch_q = 1'b0;

    always @(posedge mclk_i) begin
        if (ce_i && latch_unit_enable) begin
            if (rst_in) begin
                latch_q <= 1'b0;
            end else if (set_in) begin
                latch_q <= 1'b1;
            end
        end
    end

    assign latch_q_o = latch_q;
    assign latch_qn_o = ~latch_q;
    assign true_output_pin_o = latch_q;
    assign true_output_pin_oe_o = latch_unit_enable & true_output_pin_enable;
    assign inverted_output_pin_o = ~latch_q;
    assign inverted_output_pin_oe_o = latch_unit_enable & inverted_output_pin_enable;

    // =====================================================================
    // read data

    always @(posedge mclk_i) begin
        if (rst_i) begin
            prdata_o <= 32'h0;
        end else if (rd_en) begin
            if (srl_hit(paddr_i, `SRL_CTRL_OFS)) begin
                prdata_o <= {24'h0, ctrl_q};
            end else if (srl_hit(paddr_i, `SRL_SRC_OFS)) begin
                prdata_o <= {24'h0, src_q};
            end else if (srl_hit(paddr_i, `SRL_STAT_OFS)) begin
                prdata_o <= {28'h0, set_in, rst_in, div_pulse_q, latch_q};
            end else begin
                prdata_o <= 32'h0;
            end
        end
    end

endmodule // srl_latch_unit

// file: core/srl_map.vh
// register offsets, field positions and reset values of the set/reset latch unit
`ifndef SRL_MAP_VH
`define SRL_MAP_VH

// =====================================================================
// register byte offsets
`define SRL_CTRL_OFS 12'h000
`define SRL_SRC_OFS 12'h004
`define SRL_STAT_OFS 12'h008

// =====================================================================
// latch_control fields
`define SRL_EN_BIT 7
`define SRL_DIV_HI 6
`define SRL_DIV_LO 4
`define SRL_QEN_BIT 3
`define SRL_NQEN_BIT 2
`define SRL_PS_BIT 1
`define SRL_PR_BIT 0

// =====================================================================
// latch_source_select fields
`define SRL_S_PIN_BIT 7
`define SRL_S_CLK_BIT 6
`define SRL_S_C2_BIT 5
`define SRL_S_C1_BIT 4
`define SRL_R_PIN_BIT 3
`define SRL_R_CLK_BIT 2
`define SRL_R_C2_BIT 1
`define SRL_R_C1_BIT 0

// =====================================================================
// reset values
`define SRL_CTRL_RST 8'h00
`define SRL_SRC_RST 8'h00

// =====================================================================
// divider: period is 4 shifted left by the code
`define SRL_DIV_BASE_LOG2 2
`define SRL_DIV_CNT_W 9

`endif

// file: test/srl_latch_unit_chk.sv
// port checker for the set/reset latch unit
`timescale 1ns/1ns
`include "srl_map.vh"
module srl_latch_unit_chk (
    // clock and apb
    input wire mclk_i, input wire rst_i, input wire ce_i,
    input wire psel_i, input wire penable_i, input wire pwrite_i,
    input wire [11:0] paddr_i, input wire [31:0] pwdata_i, input wire [3:0] pstrb_i,
    input wire pslverr_o,
    // latch
    input wire external_interrupt_pin_i, input wire latch_q_o, input wire latch_qn_o,
    input wire true_output_pin_o, input wire true_output_pin_oe_o,
    input wire inverted_output_pin_o, input wire inverted_output_pin_oe_o
);
    // =====================================================================
    // shadow registers: the checker cannot see inside, so it mirrors writes
    wire wr_a = psel_i & penable_i & pwrite_i & ce_i & pstrb_i[0];
    wire wr_c = wr_a && paddr_i[11:2] == `SRL_CTRL_OFS >> 2;
    reg [7:0] ctl_q;
    reg [7:0] src_q;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    always @(posedge mclk_i) begin
        if (rst_i) begin
            ctl_q <= `SRL_CTRL_RST;
            src_q <= `SRL_SRC_RST;
        end else if (wr_c) begin
            ctl_q <= pwdata_i[7:0];
        end else if (wr_a && paddr_i[11:2] == `SRL_SRC_OFS >> 2) begin
            src_q <= pwdata_i[7:0];
        end
    end
    // =====================================================================
    // assertions
    chk_true_pin: assert property (true_output_pin_o == latch_q_o)
        else $error("true pin wrong");
    chk_inv_pin: assert property ({inverted_output_pin_o, latch_qn_o} == {2{!latch_q_o}})
        else $error("inverted pin wrong");
    chk_oe_true: assert property (true_output_pin_oe_o == (ctl_q[7] & ctl_q[3]))
        else $error("true pin enable wrong");
    chk_oe_inv: assert property (inverted_output_pin_oe_o == (ctl_q[7] & ctl_q[2]))
        else $error("inverted pin enable wrong");
    chk_err_map: assert property (psel_i && penable_i |-> pslverr_o == (paddr_i[11:2] > 10'd2))
        else $error("slave error wrong");
    chk_soft_set: assert property (wr_c && pwdata_i[7] && pwdata_i[1:0] == 2'b10
        && src_q[3:0] == 8'h0 |=> ##1 latch_q_o) else $error("soft set lost");
    chk_soft_rst: assert property (wr_c && pwdata_i[7] && pwdata_i[0] |=> ##1 !latch_q_o)
        else $error("soft reset lost");
    chk_hold_off: assert property (!ctl_q[7] |=> $stable(latch_q_o))
        else $error("latch moved while disabled");
    chk_pin_set: assert property ((ctl_q[7] && src_q == 8'h80 && external_interrupt_pin_i) [*3]
        |=> latch_q_o) else $error("pin did not set");
    cover property (wr_c && pwdata_i[1]);
    cover property (ctl_q[7] && $fell(latch_q_o));
    cover property (src_q == 8'h80 && $rose(latch_q_o));
endmodule // srl_latch_unit_chk

bind srl_latch_unit srl_latch_unit_chk u_chk (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .pslverr_o(pslverr_o),
    .external_interrupt_pin_i(external_interrupt_pin_i), .latch_q_o(latch_q_o),
    .latch_qn_o(latch_qn_o), .true_output_pin_o(true_output_pin_o),
    .true_output_pin_oe_o(true_output_pin_oe_o), .inverted_output_pin_o(inverted_output_pin_o),
    .inverted_output_pin_oe_o(inverted_output_pin_oe_o));

// file: test/tb_top.sv
// self-checking bench for the set/reset latch unit
`timescale 1ns/1ns
`include "srl_map.vh"
module tb_top;
    reg mclk_i = 0, rst_i = 1, ps = 0, pe = 0, pw = 0, ce_r = 1;
    reg [11:0] pa = 0;
    reg [31:0] pd = 0;
    reg [3:0] src = 0;
    wire rdy, q;
    wire [31:0] rd;
    int err_total = 0, n_checks = 0, i, c, r;
    logic [63:0] eq[$], h;
    srl_latch_unit uut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_r), .psel_i(ps),
        .penable_i(pe), .pwrite_i(pw), .paddr_i(pa), .pwdata_i(pd), .pstrb_i(4'hf),
        .pready_o(rdy), .prdata_o(rd), .pslverr_o(), .external_interrupt_pin_i(src[3]),
        .comparator_one_i(src[0]), .comparator_two_i(src[1]), .latch_q_o(q), .latch_qn_o(),
        .true_output_pin_o(), .true_output_pin_oe_o(), .inverted_output_pin_o(),
        .inverted_output_pin_oe_o());
    initial forever #20 mclk_i = ~mclk_i;
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s exp %h seen %h", s, e, g);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task give_up;
        err_total++;
        tally_and_finish;
    endtask
    // =====================================================================
    // apb master; the idle cycle after each transfer avoids double drives
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        ps <= 1;
        pw <= w;
        pa <= a;
        pd <= d;
        @(posedge mclk_i) pe <= 1;
        for (c = 0; c < 9; c++) begin
            @(posedge mclk_i);
            if (rdy === 1'b1) break;
        end
        if (c == 9) give_up;
        ps <= 0;
        pe <= 0;
        @(posedge mclk_i);
    endtask
    task rdx(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
        eq.push_back({m, e});
        apb(0, a, 0);
    endtask
    // counts negedges until the latch has been high and then shows its next dip
    task dip;
        c = 0;
        while (q !== 1'b1 && c < 2000)
            @(negedge mclk_i) c++;
        while (q !== 1'b0 && c < 2000)
            @(negedge mclk_i) c++;
        if (c >= 2000) give_up;
    endtask
    always @(posedge mclk_i) begin
        if (ps && pe && !pw && rdy === 1'b1) begin
            h = eq.pop_front();
            chk("prdata", h[31:0], rd & h[63:32]);
        end
    end
    // =====================================================================
    // main sequence
    initial begin
        void'($urandom(32'h73f1));
        repeat (16) @(posedge mclk_i);
        rst_i <= 0;
        @(posedge mclk_i);
        rdx(`SRL_CTRL_OFS, `SRL_CTRL_RST, '1);
        rdx(`SRL_SRC_OFS, `SRL_SRC_RST, '1);
        rdx(12'h00c, 0, '1);
        repeat (4) begin
            r = $urandom & 8'hff;
            apb(1, `SRL_SRC_OFS, r);
            rdx(`SRL_SRC_OFS, r, '1);
        end
        apb(1, `SRL_SRC_OFS, 0);
        apb(1, `SRL_CTRL_OFS, 8'h81);
        apb(1, `SRL_CTRL_OFS, 8'h8f);
        rdx(`SRL_CTRL_OFS, 8'h8c, '1);
        rdx(`SRL_STAT_OFS, 0, 1);
        apb(1, `SRL_CTRL_OFS, 8'h82);
        rdx(`SRL_STAT_OFS, 1, 1);
        // a soft reset written while the clock enable is low must be lost
        ce_r <= 0;
        apb(1, `SRL_CTRL_OFS, 8'h81);
        ce_r <= 1;
        rdx(`SRL_STAT_OFS, 1, 1);
        for (i = 0; i < 8; i++) if (i % 4 != 2) begin
            apb(1, `SRL_CTRL_OFS, i > 3 ? 8'h81 : 8'h82);
            src[i % 4] <= 1;
            repeat (4) @(posedge mclk_i);
            rdx(`SRL_STAT_OFS, i < 4, 1);
            apb(1, `SRL_SRC_OFS, 1 << i);
            repeat (4) @(posedge mclk_i);
            rdx(`SRL_STAT_OFS, i > 3, 1);
            apb(1, `SRL_SRC_OFS, 0);
            src <= 0;
        end
        apb(1, `SRL_SRC_OFS, 8'h14);
        src[0] <= 1;
        for (i = 0; i < 8; i++) begin
            apb(1, `SRL_CTRL_OFS, 8'h00);
            apb(1, `SRL_CTRL_OFS, 8'h80 | i << 4);
            dip;
            dip;
            chk("period", 4 << i, c);
            @(posedge mclk_i);
        end
        src <= 0;
        apb(1, `SRL_CTRL_OFS, 8'h00);
        for (i = 0; i < 2; i++) begin
            apb(1, `SRL_SRC_OFS, i << 6);
            apb(1, `SRL_CTRL_OFS, 8'h81);
            repeat (8) @(posedge mclk_i);
            rdx(`SRL_STAT_OFS, i, 1);
        end
        tally_and_finish;
    end
endmodule // tb_top
